// >>> tbk_pkg.sv
package tbk_pkg;
	localparam int TBK_NUM_TIMERS = 4;
	localparam int TBK_CNT_W = 24;
	localparam int TBK_ADDR_W = 8;
	// Per-timer register layout: load, current, control, clear, status
	localparam logic [7:0] TBK_TIMER_BASE = 8'h00;
	localparam logic [7:0] TBK_TIMER_STRIDE = 8'h14;
	localparam logic [7:0] TBK_OFS_LOAD = 8'h00;
	localparam logic [7:0] TBK_OFS_CUR = 8'h04;
	localparam logic [7:0] TBK_OFS_CTRL = 8'h08;
	localparam logic [7:0] TBK_OFS_CLR = 8'h0c;
	localparam logic [7:0] TBK_OFS_STAT = 8'h10;
	// Fourth timer's registers as a check of the layout
	localparam logic [7:0] TBK_ADDR_T4_CLR = 8'h48;
	localparam logic [7:0] TBK_ADDR_T4_STAT = 8'h4c;
	// Bank-wide registers
	localparam logic [7:0] TBK_ADDR_MASKED = 8'ha0;
	localparam logic [7:0] TBK_ADDR_CLR_ALL = 8'ha4;
	localparam logic [7:0] TBK_ADDR_RAW = 8'ha8;
	localparam logic [7:0] TBK_ADDR_REV = 8'hac;
	// Control fields
	localparam int TBK_CTRL_EN = 0;
	localparam int TBK_CTRL_MODE = 1;
	localparam int TBK_CTRL_MASK = 2;
	localparam logic [2:0] TBK_CTRL_RST = 3'h0;
	localparam logic [23:0] TBK_LOAD_RST = 24'h000000;
	localparam logic [23:0] TBK_CNT_MAX = 24'hffffff;
	// Revision value is arbitrary
	localparam logic [31:0] TBK_REV_DEFAULT = 32'h00010000;

	typedef enum logic [1:0] {
		TBK_ST_IDLE = 2'b01,
		TBK_ST_RESP = 2'b10
	} tbk_bus_st_t;
endpackage

// >>> tbk_timer_bank.sv
// Overview of operation
// - Control bit 2 set hides the timer's interrupt from masked status and output.
// - Control bit 1 selects free-running (0) or user-defined count (1) mode.
// - Control bit 0 enables the timer; all control bits reset to zero.
// - Reading a timer's clear register returns zero and clears its interrupt.
// - Status register bit 0 reports that timer's interrupt state, read-only.
// - Bank masked status bits 3:0 show each timer's interrupt after masking.
// - A masked status bit is one when the masked interrupt is active.
// - Reading the bank clear register returns zero and clears all interrupts.
// - Bank raw status bits 3:0 show each interrupt regardless of mask.
// - A read-only 32-bit register returns the bank revision; writes ignored.
// - Each timer has a 24-bit writable load value; upper bits read zero.
// - Each timer's live 24-bit count is readable in its current-value register.
`timescale 1ns/10ps
module tbk_timer_bank
	import tbk_pkg::*;
#(
	parameter int NUM_TIMERS = TBK_NUM_TIMERS,
	parameter logic [31:0] REVISION = TBK_REV_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Avalon-MM slave
	input wire logic [TBK_ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Interrupts
	output logic [NUM_TIMERS-1:0] o_timer_irq,
	output logic o_irq
);

	typedef struct packed {
		tbk_bus_st_t st;
		logic [31:0] rdata;
		logic [NUM_TIMERS-1:0][TBK_CNT_W-1:0] load;
		logic [NUM_TIMERS-1:0][TBK_CNT_W-1:0] cnt;
		logic [NUM_TIMERS-1:0][2:0] ctrl;
		logic [NUM_TIMERS-1:0] pend;
		logic [NUM_TIMERS-1:0] irq;
		logic irq_any;
	} tbk_state_t;

	tbk_state_t s_reg;
	tbk_state_t s_next;

	// Merge a write into a register under byte enables
	function automatic logic [31:0] tbk_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Address of a per-timer register
	function automatic logic [7:0] tbk_taddr(input int t, input logic [7:0] ofs);
		return 8'(TBK_TIMER_BASE + 8'(t) * TBK_TIMER_STRIDE + ofs);
	endfunction

	logic [NUM_TIMERS-1:0] masked;
	logic [NUM_TIMERS-1:0] zero_hit;
	logic take;

	always_comb begin
		for (int t = 0; t < NUM_TIMERS; t++) begin
			masked[t] = s_reg.pend[t] & ~s_reg.ctrl[t][TBK_CTRL_MASK];
			zero_hit[t] = s_reg.ctrl[t][TBK_CTRL_EN] && (s_reg.cnt[t] == '0);
		end
	end

	assign take = (s_reg.st == TBK_ST_IDLE) && (i_read || i_write);

	always_comb begin
		logic [31:0] rd;
		logic [31:0] w;
		logic [NUM_TIMERS-1:0] clr;
		rd = 32'h00000000;
		w = 32'h00000000;
		clr = '0;
		s_next = s_reg;
		// Read decode and read side effects
		if (take && i_read) begin
			for (int t = 0; t < NUM_TIMERS; t++) begin
				if (i_address == tbk_taddr(t, TBK_OFS_LOAD)) begin
					rd = {8'h00, s_reg.load[t]};
				end
				if (i_address == tbk_taddr(t, TBK_OFS_CUR)) begin
					rd = {8'h00, s_reg.cnt[t]};
				end
				if (i_address == tbk_taddr(t, TBK_OFS_CTRL)) begin
					rd = {29'h0, s_reg.ctrl[t]};
				end
				if (i_address == tbk_taddr(t, TBK_OFS_CLR)) begin
					clr[t] = 1'b1;
				end
				if (i_address == tbk_taddr(t, TBK_OFS_STAT)) begin
					rd = {31'h0, s_reg.pend[t]};
				end
			end
			unique case (i_address)
				TBK_ADDR_MASKED: rd = 32'(masked);
				TBK_ADDR_CLR_ALL: clr = '1;
				TBK_ADDR_RAW: rd = 32'(s_reg.pend);
				TBK_ADDR_REV: rd = REVISION;
				default: ;
			endcase
		end
		// Writes; revision and status registers ignore writes
		if (take && i_write) begin
			for (int t = 0; t < NUM_TIMERS; t++) begin
				if (i_address == tbk_taddr(t, TBK_OFS_LOAD)) begin
					w = tbk_merge({8'h00, s_reg.load[t]}, i_writedata, i_byteenable);
					s_next.load[t] = w[TBK_CNT_W-1:0];
				end
				if (i_address == tbk_taddr(t, TBK_OFS_CTRL)) begin
					w = tbk_merge({29'h0, s_reg.ctrl[t]}, i_writedata, i_byteenable);
					s_next.ctrl[t] = w[2:0];
				end
			end
		end
		// Counting; a new interrupt wins over a clear in the same cycle
		for (int t = 0; t < NUM_TIMERS; t++) begin
			if (take && i_write && (i_address == tbk_taddr(t, TBK_OFS_CTRL)) &&
				w[TBK_CTRL_EN] && !s_reg.ctrl[t][TBK_CTRL_EN]) begin
				s_next.cnt[t] = s_reg.load[t];
			end else if (zero_hit[t]) begin
				s_next.cnt[t] = s_reg.ctrl[t][TBK_CTRL_MODE] ? s_reg.load[t] : TBK_CNT_MAX;
			end else if (s_reg.ctrl[t][TBK_CTRL_EN]) begin
				s_next.cnt[t] = s_reg.cnt[t] - 24'h000001;
			end
			s_next.pend[t] = zero_hit[t] | (s_reg.pend[t] & ~clr[t]);
		end
		// Bus answer one cycle after the request is seen
		unique case (s_reg.st)
			TBK_ST_IDLE: begin
				if (take) begin
					s_next.st = TBK_ST_RESP;
					s_next.rdata = rd;
				end
			end
			TBK_ST_RESP: begin
				s_next.st = TBK_ST_IDLE;
			end
			default: s_next.st = TBK_ST_IDLE;
		endcase
		for (int t = 0; t < NUM_TIMERS; t++) begin
			s_next.irq[t] = s_next.pend[t] & ~s_next.ctrl[t][TBK_CTRL_MASK];
		end
		s_next.irq_any = |s_next.irq;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_reg.st <= TBK_ST_IDLE;
			s_reg.rdata <= 32'h00000000;
			s_reg.load <= {NUM_TIMERS{TBK_LOAD_RST}};
			s_reg.cnt <= {NUM_TIMERS{TBK_LOAD_RST}};
			s_reg.ctrl <= {NUM_TIMERS{TBK_CTRL_RST}};
			s_reg.pend <= '0;
			s_reg.irq <= '0;
			s_reg.irq_any <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_waitrequest = (i_read || i_write) && (s_reg.st != TBK_ST_RESP);
	assign o_readdata = s_reg.rdata;
	assign o_timer_irq = s_reg.irq;
	assign o_irq = s_reg.irq_any;

endmodule

// >>> tbk_timer_bank_props.sv
`timescale 1ns/10ps
module tbk_timer_bank_props
	import tbk_pkg::*;
#(
	parameter int NUM_TIMERS = TBK_NUM_TIMERS,
	parameter logic [31:0] REVISION = TBK_REV_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Bus
	input wire logic [TBK_ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	// Interrupts
	input wire logic o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic rd_ok = i_read && !o_waitrequest;
	a_one_wait_state: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("no answer after one wait");
	a_read_starts_wait: assert property ($rose(i_read) |-> o_waitrequest)
		else $error("read answered without wait");
	a_clear_reads_zero: assert property (rd_ok && i_address == TBK_ADDR_T4_CLR |-> o_readdata == 32'h0)
		else $error("clear read not zero");
	a_clear_all_zero: assert property (rd_ok && i_address == TBK_ADDR_CLR_ALL |-> o_readdata == 32'h0)
		else $error("clear all read not zero");
	a_revision_value: assert property (rd_ok && i_address == TBK_ADDR_REV |-> o_readdata == REVISION)
		else $error("bad revision");
	a_masked_upper_zero: assert property (rd_ok && i_address == TBK_ADDR_MASKED |-> o_readdata[31:4] == 28'h0)
		else $error("masked status upper bits set");
	a_raw_upper_zero: assert property (rd_ok && i_address == TBK_ADDR_RAW |-> o_readdata[31:4] == 28'h0)
		else $error("raw status upper bits set");
	a_status_upper_zero: assert property (rd_ok && i_address == TBK_ADDR_T4_STAT |-> o_readdata[31:1] == 31'h0)
		else $error("status upper bits set");
	cover property (rd_ok && i_address == TBK_ADDR_CLR_ALL);
	cover property ($rose(o_irq));
	cover property ($fell(o_irq));
endmodule
bind tbk_timer_bank tbk_timer_bank_props #(.NUM_TIMERS(NUM_TIMERS), .REVISION(REVISION)) i_tbk_timer_bank_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq));

// >>> tbk_timer_bank_tb.sv
`timescale 1ns/10ps
module tbk_timer_bank_tb import tbk_pkg::*;;
	logic i_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0, o_waitrequest, o_irq;
	logic [7:0] i_address = 8'h00;
	logic [31:0] i_writedata = 32'h0, o_readdata, q;
	logic [3:0] o_timer_irq, i_byteenable = 4'hf;
	int num_errors = 0, n_checks = 0;
	always #25 i_clk = ~i_clk;
	tbk_timer_bank i_tbk_timer_bank (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_timer_irq(o_timer_irq), .o_irq(o_irq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_address <= a;
		i_writedata <= d;
		i_write <= w;
		i_read <= !w;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		acc(1'b0, a, 32'h0);
		chk(q, e, nm);
	endtask
	task automatic wirq;
		for (int k = 0; k < 40 && o_irq !== 1'b1; k++) @(posedge i_clk);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge i_clk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rc(8'h44, 32'h0, "control reset");
		acc(1'b1, TBK_ADDR_REV, 32'h0);
		rc(TBK_ADDR_REV, TBK_REV_DEFAULT, "revision");
		rc(8'hfc, 32'h0, "unmapped");
		acc(1'b1, 8'h3c, 32'hffffffff);
		rc(8'h3c, 32'h00ffffff, "load");
		i_byteenable <= 4'h1;
		acc(1'b1, 8'h3c, 32'h00000003);
		i_byteenable <= 4'hf;
		rc(8'h3c, 32'h00ffff03, "load byte merge");
		acc(1'b1, 8'h3c, 32'h3);
		acc(1'b1, 8'h44, 32'h3);
		wirq;
		chk(o_timer_irq, 32'h8, "irq line");
		acc(1'b0, 8'h40, 32'h0);
		chk(q[31:2], 32'h0, "reloaded count");
		acc(1'b1, 8'h44, 32'h6);
		chk(o_irq, 32'h0, "irq masked");
		rc(8'h44, 32'h6, "control");
		rc(TBK_ADDR_MASKED, 32'h0, "masked");
		rc(TBK_ADDR_RAW, 32'h8, "raw");
		rc(TBK_ADDR_T4_STAT, 32'h1, "status");
		rc(TBK_ADDR_T4_CLR, 32'h0, "clear");
		rc(TBK_ADDR_T4_STAT, 32'h0, "status cleared");
		acc(1'b1, 8'h3c, 32'h2);
		acc(1'b1, 8'h44, 32'h1);
		wirq;
		rc(TBK_ADDR_MASKED, 32'h8, "masked set");
		acc(1'b0, 8'h40, 32'h0);
		chk(q[31:16], 32'hff, "wrapped count");
		rc(TBK_ADDR_CLR_ALL, 32'h0, "clear all");
		rc(TBK_ADDR_RAW, 32'h0, "raw cleared");
		chk(o_irq, 32'h0, "irq low");
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rc(8'h44, 32'h0, "control after reset");
		rc(8'h3c, 32'h0, "load after reset");
		tally_and_finish;
	end
endmodule
